// [logic/rdw_count.sv]
// Message byte count calculation and legal range check.
`timescale 1ns/1ps
module rdw_count (
   input  wire logic [rdw_pkg::CNT_W-1:0] frameLen,
   input  wire logic [rdw_pkg::CNT_W-1:0] lengthField,
   input  wire logic                      stripEn,
   output logic      [rdw_pkg::CNT_W-1:0] msgCount,
   output logic                           inRange
);
   import rdw_pkg::*;

   always_comb
   begin
      if (stripEn && (lengthField < PAD_MIN_LEN))
         msgCount = CNT_W'(HDR_LEN + lengthField);
      else
         msgCount = frameLen;
      inRange = ((msgCount >= CNT_MIN) && (msgCount <= CNT_SHORT_MX))
             || (msgCount >= CNT_LONG_MIN);
   end
endmodule

// [logic/rdw_pkg.sv]
// Package with constants and types for the receive descriptor status write-back block.
package rdw_pkg;
   localparam int unsigned REG_AW = 5;
   localparam int unsigned DW     = 32;
   localparam int unsigned TAG_W  = 15;
   localparam int unsigned CNT_W  = 16;
   localparam int unsigned EV_W   = 3;
   // Register offsets.
   localparam logic [REG_AW-1:0] OFS_CTRL    = 5'h00;
   localparam logic [REG_AW-1:0] OFS_STATUS  = 5'h04;
   localparam logic [REG_AW-1:0] OFS_MASK    = 5'h08;
   localparam logic [REG_AW-1:0] OFS_LASTCNT = 5'h0C;
   localparam logic [REG_AW-1:0] OFS_WBCNT   = 5'h10;
   // Control register field positions.
   localparam int unsigned CTRL_STYLE_LSB = 0;
   localparam int unsigned CTRL_BCREJ_BIT = 8;
   localparam int unsigned CTRL_TAGEN_BIT = 9;
   localparam int unsigned CTRL_STRIP_BIT = 10;
   // Reset values.
   localparam logic [7:0]      STYLE_RST = 8'h00;
   localparam logic            BCREJ_RST = 1'b0;
   localparam logic            TAGEN_RST = 1'b0;
   localparam logic            STRIP_RST = 1'b0;
   localparam logic [EV_W-1:0] MASK_RST  = 3'h0;
   // Event bit positions in status and mask.
   localparam int unsigned EV_DONE  = 0;
   localparam int unsigned EV_ERR   = 1;
   localparam int unsigned EV_RANGE = 2;
   // Descriptor word offsets and layout.
   localparam logic [DW-1:0] DESC_W1_OFS = 32'h0000_0004;
   localparam logic [DW-1:0] DESC_W2_OFS = 32'h0000_0008;
   localparam logic [3:0]    BE_ALL      = 4'hF;
   localparam logic [3:0]    BE_W1       = 4'hC;
   localparam int unsigned   W1_OWN  = 31;
   localparam int unsigned   W1_ERR  = 30;
   localparam int unsigned   W1_STP  = 25;
   localparam int unsigned   W1_ENP  = 24;
   localparam int unsigned   W1_PAM  = 22;
   localparam int unsigned   W1_HASH = 21;
   localparam int unsigned   W1_BCST = 20;
   localparam int unsigned   W2_TAG_LSB = 16;
   // Message byte count figures.
   localparam logic [CNT_W-1:0] PAD_MIN_LEN  = 16'h002E;
   localparam logic [CNT_W-1:0] HDR_LEN      = 16'h000E;
   localparam logic [CNT_W-1:0] CNT_MIN      = 16'h000F;
   localparam logic [CNT_W-1:0] CNT_SHORT_MX = 16'h003B;
   localparam logic [CNT_W-1:0] CNT_LONG_MIN = 16'h0040;
   typedef enum logic [2:0] {
      S_IDLE = 3'b001,
      S_W2   = 3'b010,
      S_W1   = 3'b100
   } rdw_state_t;
endpackage

// [logic/rdw_sync.sv]
// Two flip-flop synchroniser for a bus of levels.
`timescale 1ns/1ps
module rdw_sync #(
   parameter int unsigned W = 1
) (
   input  wire logic         sys_clk,
   input  wire logic         reset,
   input  wire logic [W-1:0] asyncIn,
   output logic      [W-1:0] syncOut
);
   logic [W-1:0] stage1_ff;

   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         stage1_ff <= '0;
         syncOut   <= '0;
      end
      else
      begin
         stage1_ff <= asyncIn;
         syncOut   <= stage1_ff;
      end
   end
endmodule

// [logic/rdw_writeback.sv]
// Receive descriptor status write-back engine with its control registers.
//
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module rdw_writeback (
   input  wire logic                       sys_clk,
   input  wire logic                       reset,
   input  wire logic [rdw_pkg::REG_AW-1:0] regAddr,
   input  wire logic [rdw_pkg::DW-1:0]     regWrData,
   input  wire logic                       regWrStb,
   input  wire logic                       regRdStb,
   output logic      [rdw_pkg::DW-1:0]     regRdData,
   output logic                            irq,
   input  wire logic                       bufDone,
   output logic                            bufReady,
   input  wire logic [rdw_pkg::DW-1:0]     descBase,
   input  wire logic                       startOfFrame,
   input  wire logic                       endOfFrame,
   input  wire logic [rdw_pkg::CNT_W-1:0]  frameLen,
   input  wire logic [rdw_pkg::CNT_W-1:0]  lengthField,
   input  wire logic                       isBroadcast,
   input  wire logic                       hashPass,
   input  wire logic                       physMatch,
   input  wire logic                       framingErr,
   input  wire logic                       overflowErr,
   input  wire logic                       crcErr,
   input  wire logic [rdw_pkg::TAG_W-1:0]  addressDetectTag,
   output logic                            descWrValid,
   input  wire logic                       descWrReady,
   output logic      [rdw_pkg::DW-1:0]     descWrAddr,
   output logic      [rdw_pkg::DW-1:0]     descWrData,
   output logic      [3:0]                 descWrBe
);
   import rdw_pkg::*;

   rdw_state_t             state_ff;
   logic [7:0]             styleSel_ff;
   logic                   bcRejEn_ff;
   logic                   tagEn_ff;
   logic                   stripEn_ff;
   logic [EV_W-1:0]        status_ff;
   logic [EV_W-1:0]        mask_ff;
   logic [CNT_W-1:0]       lastCnt_ff;
   logic [DW-1:0]          wbCnt_ff;
   logic [DW-1:0]          word1_ff;
   logic                   rangeBad_ff;
   logic [TAG_W-1:0]       tagSync;
   logic [CNT_W-1:0]       msgCount;
   logic                   cntInRange;
   logic                   styleOn;
   logic                   take;
   logic                   w2Done;
   logic                   w1Done;
   logic                   errSum;
   logic                   hashFlag;
   logic                   bcastFlag;
   logic                   physFlag;
   logic [DW-1:0]          nxt_word1;
   logic [DW-1:0]          nxt_word2;
   logic [EV_W-1:0]        events;
   logic [DW-1:0]          nxt_rdData;

   rdw_sync #(
      .W (TAG_W)
   ) u_tag_sync (
      .sys_clk (sys_clk),
      .reset   (reset),
      .asyncIn (addressDetectTag),
      .syncOut (tagSync)
   );

   rdw_count u_count (
      .frameLen    (frameLen),
      .lengthField (lengthField),
      .stripEn     (stripEn_ff),
      .msgCount    (msgCount),
      .inRange     (cntInRange)
   );

   // Descriptor word assembly at capture.
   always_comb
   begin
      styleOn   = (styleSel_ff != 8'h00);
      errSum    = framingErr | overflowErr | crcErr;
      hashFlag  = endOfFrame & styleOn & hashPass;
      hashFlag  = hashFlag & (~isBroadcast | bcRejEn_ff);
      bcastFlag = endOfFrame & styleOn & isBroadcast & ~bcRejEn_ff;
      physFlag  = endOfFrame & styleOn & physMatch;
      nxt_word1 = '0;
      nxt_word1[W1_OWN]  = 1'b0;
      nxt_word1[W1_ERR]  = errSum;
      nxt_word1[29]      = framingErr;
      nxt_word1[28]      = overflowErr;
      nxt_word1[27]      = crcErr;
      nxt_word1[W1_STP]  = startOfFrame;
      nxt_word1[W1_ENP]  = endOfFrame;
      nxt_word1[W1_PAM]  = physFlag;
      nxt_word1[W1_HASH] = hashFlag;
      nxt_word1[W1_BCST] = bcastFlag;
      nxt_word2 = '0;
      nxt_word2[W2_TAG_LSB +: TAG_W] = tagEn_ff ? tagSync : '0;
      nxt_word2[CNT_W-1:0] = endOfFrame ? msgCount : '0;
   end

   assign bufReady = (state_ff == S_IDLE);
   assign take     = bufDone & bufReady;
   assign w2Done   = (state_ff == S_W2) & descWrReady;
   assign w1Done   = (state_ff == S_W1) & descWrReady;

   // Write-back sequencer: third word first, ownership word last.
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
         state_ff <= S_IDLE;
      else
      begin
         case (state_ff)
            S_IDLE:  if (take) state_ff <= S_W2;
            S_W2:    if (descWrReady) state_ff <= S_W1;
            S_W1:    if (descWrReady) state_ff <= S_IDLE;
            default: state_ff <= S_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         descWrValid <= 1'b0;
         descWrAddr  <= '0;
         descWrData  <= '0;
         descWrBe    <= '0;
         word1_ff    <= '0;
         rangeBad_ff <= 1'b0;
      end
      else if (take)
      begin
         descWrValid <= 1'b1;
         descWrAddr  <= DW'(descBase + DESC_W2_OFS);
         descWrData  <= nxt_word2;
         descWrBe    <= BE_ALL;
         word1_ff    <= nxt_word1;
         rangeBad_ff <= endOfFrame & ~cntInRange;
      end
      else if (w2Done)
      begin
         descWrAddr <= DW'(descWrAddr - DESC_W2_OFS + DESC_W1_OFS);
         descWrData <= word1_ff;
         descWrBe   <= BE_W1;
      end
      else if (w1Done)
      begin
         descWrValid <= 1'b0;
      end
   end

   // Control register.
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         styleSel_ff <= STYLE_RST;
         bcRejEn_ff  <= BCREJ_RST;
         tagEn_ff    <= TAGEN_RST;
         stripEn_ff  <= STRIP_RST;
      end
      else if (regWrStb && (regAddr == OFS_CTRL))
      begin
         styleSel_ff <= regWrData[CTRL_STYLE_LSB +: 8];
         bcRejEn_ff  <= regWrData[CTRL_BCREJ_BIT];
         tagEn_ff    <= regWrData[CTRL_TAGEN_BIT];
         stripEn_ff  <= regWrData[CTRL_STRIP_BIT];
      end
   end

   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
         mask_ff <= MASK_RST;
      else if (regWrStb && (regAddr == OFS_MASK))
         mask_ff <= regWrData[EV_W-1:0];
   end

   // Sticky events; a read clears them but a same-cycle event survives.
   always_comb
   begin
      events = '0;
      events[EV_DONE]  = w1Done;
      events[EV_ERR]   = w1Done & word1_ff[W1_ERR];
      events[EV_RANGE] = w1Done & rangeBad_ff;
   end

   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
         status_ff <= '0;
      else if (regRdStb && (regAddr == OFS_STATUS))
         status_ff <= events;
      else
         status_ff <= status_ff | events;
   end

   assign irq = |(status_ff & mask_ff);

   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         lastCnt_ff <= '0;
         wbCnt_ff   <= '0;
      end
      else
      begin
         if (w2Done && word1_ff[W1_ENP])
            lastCnt_ff <= descWrData[CNT_W-1:0];
         if (w1Done)
            wbCnt_ff <= DW'(wbCnt_ff + 32'h0000_0001);
      end
   end

   // Register read port, data one cycle after the strobe.
   always_comb
   begin
      nxt_rdData = '0;
      case (regAddr)
         OFS_CTRL:
         begin
            nxt_rdData[CTRL_STYLE_LSB +: 8] = styleSel_ff;
            nxt_rdData[CTRL_BCREJ_BIT]      = bcRejEn_ff;
            nxt_rdData[CTRL_TAGEN_BIT]      = tagEn_ff;
            nxt_rdData[CTRL_STRIP_BIT]      = stripEn_ff;
         end
         OFS_STATUS:  nxt_rdData[EV_W-1:0]  = status_ff;
         OFS_MASK:    nxt_rdData[EV_W-1:0]  = mask_ff;
         OFS_LASTCNT: nxt_rdData[CNT_W-1:0] = lastCnt_ff;
         OFS_WBCNT:   nxt_rdData            = wbCnt_ff;
         default:     nxt_rdData            = '0;
      endcase
   end

   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
         regRdData <= '0;
      else if (regRdStb)
         regRdData <= nxt_rdData;
      else
         regRdData <= '0;
   end

   property p_lenKept;
      @(posedge sys_clk) disable iff (reset)
      (descWrValid && (state_ff == S_W1)) |-> (descWrBe[1:0] == 2'b00);
   endproperty
   a_lenKept: assert property (p_lenKept) else $error("Buffer length lanes enabled.");

   property p_rsvdW1;
      @(posedge sys_clk) disable iff (reset)
      (state_ff == S_W1) |-> (descWrData[19:16] == 4'h0) && !descWrData[31]
                              && !descWrData[26] && !descWrData[23];
   endproperty
   a_rsvdW1: assert property (p_rsvdW1) else $error("Reserved or own bit set.");

   property p_rsvdW2;
      @(posedge sys_clk) disable iff (reset)
      (state_ff == S_W2) |-> !descWrData[31];
   endproperty
   a_rsvdW2: assert property (p_rsvdW2) else $error("Third word bit 31 set.");

   property p_tagOff;
      @(posedge sys_clk) disable iff (reset)
      (take && !tagEn_ff) |=> (descWrData[30:16] == 15'h0000);
   endproperty
   a_tagOff: assert property (p_tagOff) else $error("Tag written while disabled.");

   property p_style0;
      @(posedge sys_clk) disable iff (reset)
      (take && (styleSel_ff == 8'h00)) |=> (word1_ff[22:20] == 3'b000);
   endproperty
   a_style0: assert property (p_style0) else $error("Match flag in 16-bit style.");

   property p_bcNoHash;
      @(posedge sys_clk) disable iff (reset)
      (take && endOfFrame && isBroadcast && !bcRejEn_ff && styleOn)
         |=> (word1_ff[21:20] == 2'b01);
   endproperty
   a_bcNoHash: assert property (p_bcNoHash) else $error("Broadcast flags wrong.");

   property p_bcHash;
      @(posedge sys_clk) disable iff (reset)
      (take && endOfFrame && isBroadcast && bcRejEn_ff && hashPass && styleOn)
         |=> (word1_ff[21:20] == 2'b10);
   endproperty
   a_bcHash: assert property (p_bcHash) else $error("Hash flag missing on broadcast.");

   property p_errOr;
      @(posedge sys_clk) disable iff (reset)
      (state_ff == S_W1) |-> (descWrData[30] == (|descWrData[29:27]));
   endproperty
   a_errOr: assert property (p_errOr) else $error("Error summary mismatch.");

   property p_order;
      @(posedge sys_clk) disable iff (reset)
      w2Done |=> descWrValid && (descWrBe == 4'hC)
                 && (descWrAddr == $past(descWrAddr) - 32'h0000_0004);
   endproperty
   a_order: assert property (p_order) else $error("Ownership word not next.");

   property p_cnt;
      @(posedge sys_clk) disable iff (reset)
      (take && endOfFrame && stripEn_ff && (lengthField < 16'h002E))
         |=> (descWrData[15:0] == $past(lengthField) + 16'h000E);
   endproperty
   a_cnt: assert property (p_cnt) else $error("Stripped count wrong.");

   property p_noEnpCnt;
      @(posedge sys_clk) disable iff (reset)
      (take && !endOfFrame) |=> (descWrData[15:0] == 16'h0000) && !word1_ff[24];
   endproperty
   a_noEnpCnt: assert property (p_noEnpCnt) else $error("Count without end flag.");
endmodule

// [sim/rdw_mem_model.sv]
// Host memory model holding one receive descriptor.
`timescale 1ns/1ps
module rdw_mem_model (
   input  wire logic        sys_clk,
   input  wire logic        reset,
   input  wire logic        prime,
   input  wire logic [15:0] bufSize,
   input  wire logic        slowEn,
   input  wire logic        descWrValid,
   output logic             descWrReady,
   input  wire logic [31:0] descWrAddr,
   input  wire logic [31:0] descWrData,
   input  wire logic [3:0]  descWrBe,
   output logic [31:0]      word [4],
   output logic [7:0]       wrCnt
);
   logic [7:0] lfsr_ff;
   // Slow mode stalls writes in a pseudo-random pattern.
   assign descWrReady = !slowEn | lfsr_ff[0];
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
         lfsr_ff <= 8'h5A;
      else
         lfsr_ff <= {lfsr_ff[6:0], lfsr_ff[7] ^ lfsr_ff[5] ^ lfsr_ff[4] ^ lfsr_ff[3]};
   end
   // The driver hands a fresh descriptor to the device before each buffer.
   always_ff @(posedge sys_clk)
   begin
      if (prime)
      begin
         word[0] <= 32'h0001_2340;
         word[1] <= {1'b1, 15'h0000, ~bufSize + 16'h0001};
         word[2] <= 32'h0000_0000;
         word[3] <= 32'hC0DE_5A5A;
         wrCnt   <= 8'h00;
      end
      else if (descWrValid && descWrReady)
      begin
         for (int b = 0; b < 4; b++)
            if (descWrBe[b])
               word[descWrAddr[3:2]][8*b +: 8] <= descWrData[8*b +: 8];
         wrCnt <= wrCnt + 8'h01;
      end
   end
endmodule

// [sim/tb_top.sv]
// Testbench for the receive descriptor write-back engine.
`timescale 1ns/1ps
module tb_top;
   import rdw_pkg::*;
   logic        sys_clk = 1'b0;
   logic        reset = 1'b1;
   logic [4:0]  regAddr = 5'h00;
   logic [31:0] regWrData = 32'h0;
   logic        regWrStb = 1'b0;
   logic        regRdStb = 1'b0;
   logic [31:0] regRdData;
   logic        irq;
   logic        bufDone = 1'b0;
   logic        bufReady;
   logic        startOfFrame = 1'b0;
   logic        endOfFrame = 1'b0;
   logic [15:0] frameLen = 16'h0;
   logic [15:0] lengthField = 16'h0;
   logic        isBroadcast = 1'b0;
   logic        hashPass = 1'b0;
   logic        physMatch = 1'b0;
   logic        framingErr = 1'b0;
   logic        overflowErr = 1'b0;
   logic        crcErr = 1'b0;
   logic [14:0] addressDetectTag = 15'h0;
   logic        descWrValid;
   logic        descWrReady;
   logic [31:0] descWrAddr;
   logic [31:0] descWrData;
   logic [3:0]  descWrBe;
   logic        prime = 1'b0;
   logic        slowEn = 1'b0;
   logic [15:0] bufSize = 16'h0;
   logic [31:0] word [4];
   logic [7:0]  wrCnt;
   logic [7:0]  sty;
   int          seed = 32'hd917e42c;
   int          error_cnt = 0;
   int          checked = 0;

   rdw_writeback dut (.sys_clk, .reset, .regAddr, .regWrData, .regWrStb, .regRdStb,
      .regRdData, .irq, .bufDone, .bufReady, .descBase(32'h0004_0000), .startOfFrame,
      .endOfFrame, .frameLen, .lengthField, .isBroadcast, .hashPass, .physMatch,
      .framingErr, .overflowErr, .crcErr, .addressDetectTag, .descWrValid,
      .descWrReady, .descWrAddr, .descWrData, .descWrBe);
   rdw_mem_model host (.sys_clk, .reset, .prime, .bufSize, .slowEn, .descWrValid,
      .descWrReady, .descWrAddr, .descWrData, .descWrBe, .word, .wrCnt);

   always #5 sys_clk = ~sys_clk;

   task automatic chk(logic [31:0] seen, logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(logic [4:0] a, logic [31:0] v);
      @(posedge sys_clk);
      regAddr <= a;
      regWrData <= v;
      regWrStb <= 1'b1;
      @(posedge sys_clk);
      regWrStb <= 1'b0;
   endtask

   task automatic rd(logic [4:0] a, output logic [31:0] v);
      @(posedge sys_clk);
      regAddr <= a;
      regRdStb <= 1'b1;
      @(posedge sys_clk);
      regRdStb <= 1'b0;
      #1;
      v = regRdData;
   endtask

   function automatic logic [15:0] expCount(logic strip, logic [15:0] len, logic [15:0] flen);
      return (strip && len < PAD_MIN_LEN) ? 16'(len + HDR_LEN) : flen;
   endfunction

   function automatic logic countLegal(logic [15:0] cnt);
      return ((cnt >= CNT_MIN) && (cnt <= CNT_SHORT_MX)) || (cnt >= CNT_LONG_MIN);
   endfunction

   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   initial
   begin
      #200000;
      error_cnt++;
      conclude();
   end

   initial
   begin
      logic [31:0] d;
      logic [31:0] r;
      logic [15:0] fl;
      logic [15:0] lf;
      logic [15:0] c;
      logic        f;
      logic        e;
      logic [2:0]  es;
      int          n;
      repeat (3) @(posedge sys_clk);
      reset <= 1'b0;
      chk(irq, 1'b0);
      rd(OFS_CTRL, d);
      chk(d[10:0], 11'h000);
      rd(OFS_MASK, d);
      chk(d[2:0], 3'h0);
      rd(5'h14, d);
      chk(d, 32'h0);
      wr(5'h18, 32'hFFFF_FFFF);
      rd(OFS_CTRL, d);
      chk(d[10:0], 11'h000);
      wr(OFS_CTRL, 32'h0000_05A5);
      rd(OFS_CTRL, d);
      chk(d[10:0], 11'h5A5);
      $display("Register test done");
      for (int i = 0; i < 60; i++)
      begin
         r = $random(seed);
         fl = 16'($random(seed)) & 16'h07FF;
         lf = 16'($random(seed)) & 16'h003F;
         sty = (i % 3 == 0) ? 8'h00 : 8'($random(seed));
         case (i)
            0, 1:
            begin
               r[7:4] = 4'b1101;
               r[0] = i[0];
               sty = 8'h02;
            end
            2:
            begin
               r[8:4] = 5'b11101;
               sty = 8'h00;
            end
            3, 4:
            begin
               r[4:2] = 3'b101;
               lf = i == 3 ? 16'h002D : 16'h002E;
               fl = 16'h0040;
            end
            5:
            begin
               r[4] = 1'b1;
               r[2] = 1'b0;
               fl = 16'h003C;
            end
            6: r[19:18] = 2'b11;
            7: r[1] = 1'b0;
            8: r[17:9] = 9'h1FF;
            default: ;
         endcase
         wr(OFS_CTRL, {21'h0, r[2], r[1], r[0], sty});
         wr(OFS_MASK, {29'h0, r[17:15]});
         @(posedge sys_clk);
         prime <= 1'b1;
         bufSize <= 16'($random(seed));
         slowEn <= r[19];
         startOfFrame <= r[3];
         endOfFrame <= r[4] | r[5];
         isBroadcast <= r[6];
         hashPass <= r[7];
         physMatch <= r[8];
         framingErr <= r[9] & r[10];
         overflowErr <= r[11] & r[12];
         crcErr <= r[13] & r[14];
         frameLen <= fl;
         lengthField <= lf;
         addressDetectTag <= 15'($random(seed));
         @(posedge sys_clk);
         prime <= 1'b0;
         repeat (3) @(posedge sys_clk);
         bufDone <= 1'b1;
         @(posedge sys_clk);
         bufDone <= r[18];
         @(posedge sys_clk);
         bufDone <= 1'b0;
         #1;
         n = 0;
         while (bufReady !== 1'b1 && n < 200)
         begin
            @(posedge sys_clk);
            #1;
            n++;
         end
         chk(n < 200, 1'b1);
         f = endOfFrame && sty != 8'h00;
         c = expCount(r[2], lf, fl);
         es = {endOfFrame & !countLegal(c), framingErr | overflowErr | crcErr, 1'b1};
         chk(wrCnt, 8'h02);
         chk(word[0], 32'h0001_2340);
         chk(word[3], 32'hC0DE_5A5A);
         chk(word[1][15:0], 16'(~bufSize + 16'h0001));
         chk(word[1][31], 1'b0);
         chk(word[1][30:27], {framingErr | overflowErr | crcErr, framingErr, overflowErr,
            crcErr});
         chk(word[1][25:24], {startOfFrame, endOfFrame});
         chk(word[1][22], f & physMatch);
         chk(word[1][21], f & hashPass & (!isBroadcast | r[0]));
         chk(word[1][20], f & isBroadcast & !r[0]);
         chk({word[1][26], word[1][23], word[1][19:16], word[2][31]}, 7'h00);
         chk(word[2][30:16], r[1] ? addressDetectTag : 15'h0000);
         chk(word[2][15:0], endOfFrame ? c : 16'h0000);
         e = irq;
         rd(OFS_STATUS, d);
         chk(e, |(es & r[17:15]));
         chk(d[0], 1'b1);
         chk(d[1], es[1]);
         chk(d[2], es[2]);
         if (endOfFrame)
         begin
            rd(OFS_LASTCNT, d);
            chk(d[15:0], c);
         end
         chk(irq, 1'b0);
         $display("Buffer test %0d done", i);
      end
      conclude();
   end
endmodule
